// ==== core/ast_tx.sv ====
// asynchronous serial transmitter with apb register access
`timescale 1ns/100ps
`include "ast_cfg.svh"
module ast_tx #(
   parameter int unsigned BAUD_W = 8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire ast_pkg::ast_apb_req_s apb_req_i,
   output ast_pkg::ast_apb_rsp_s apb_rsp_o,
   input wire logic rx_pin_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_n_o,
   output logic rx_pin_o,
   output logic rx_pin_oe_n_o,
   output logic rx_level_o,
   output logic irq_o
);
   import ast_pkg::*;

   // ************************************************************
   // register bus
   // ************************************************************
   logic [7:0] txsc_reg;
   logic [7:0] rxsc_reg;
   logic [BAUD_W-1:0] baud_reg;
   logic [7:0] hold_reg;
   logic [2:0] intc_reg;
   logic hold_full_reg;
   logic hold_nine_reg;
   logic flag_reg;
   logic [1:0] wr_age_reg;
   logic [31:0] rdata_reg;
   logic ready_reg;
   logic err_reg;
   logic [7:0] port_latch_reg;

   wire setup = apb_req_i.psel & ~apb_req_i.penable;
   // writes land only at the access edge where pready is seen high
   wire acc_phase = apb_req_i.psel & apb_req_i.penable & ready_reg;
   wire wr_en = acc_phase & apb_req_i.pwrite;
   wire rd_en = setup & ~apb_req_i.pwrite;
   wire sel_txsc = apb_req_i.paddr == `AST_OFF_TXSC;
   wire sel_rxsc = apb_req_i.paddr == `AST_OFF_RXSC;
   wire sel_baud = apb_req_i.paddr == `AST_OFF_BAUD;
   wire sel_hold = apb_req_i.paddr == `AST_OFF_HOLD;
   wire sel_intc = apb_req_i.paddr == `AST_OFF_INTC;
   wire sel_flag = apb_req_i.paddr == `AST_OFF_FLAG;
   wire mapped = sel_txsc | sel_rxsc | sel_baud | sel_hold | sel_intc | sel_flag;
   wire wr_txsc = wr_en & sel_txsc;
   wire wr_hold = wr_en & sel_hold;

   // ************************************************************
   // status and derived controls
   // ************************************************************
   ast_state_e state_reg;
   logic [8:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [BAUD_W-1:0] baud_cnt_reg;
   logic tx_line_reg;
   logic shift_reg_empty_reg;

   wire serial_port_enable = rxsc_reg[`AST_BIT_SERIAL_PORT_ENABLE];
   wire transmit_enable = txsc_reg[`AST_BIT_TRANSMIT_ENABLE];
   // transmit path runs only in asynchronous mode with both enables
   wire tx_active = transmit_enable & ~txsc_reg[`AST_BIT_SYNC] & serial_port_enable;
   wire nine = txsc_reg[`AST_BIT_NINE];
   wire [7:0] txsc_rd = {txsc_reg[7:2], shift_reg_empty_reg, txsc_reg[`AST_BIT_NINTH]};
   wire [7:0] rx_rd = {rxsc_reg[7:1], rx_level_o};
   wire [31:0] rd_mux =
      sel_txsc ? {24'h000000, txsc_rd} :
      sel_rxsc ? {24'h000000, rx_rd} :
      sel_baud ? {{(32-BAUD_W){1'b0}}, baud_reg} :
      sel_intc ? {29'h00000000, intc_reg} :
      sel_flag ? {31'h00000000, flag_reg} : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ready_reg <= setup;
         err_reg <= setup & ~mapped;
         rdata_reg <= rd_en ? rd_mux : 32'h00000000;
      end
   end
   assign apb_rsp_o = '{pready: ready_reg, pslverr: err_reg, prdata: rdata_reg};

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         txsc_reg <= `AST_TXSC_RESET;
         rxsc_reg <= `AST_RXSC_RESET;
         baud_reg <= BAUD_W'(`AST_BAUD_RESET);
         intc_reg <= 3'b000;
      end else begin
         if (wr_txsc)
            txsc_reg <= apb_req_i.pwdata[7:0];
         if (wr_en & sel_rxsc)
            rxsc_reg <= apb_req_i.pwdata[7:0];
         if (wr_en & sel_baud)
            baud_reg <= apb_req_i.pwdata[BAUD_W-1:0];
         if (wr_en & sel_intc)
            intc_reg <= apb_req_i.pwdata[2:0];
      end
   end

   // ************************************************************
   // holding register and buffer empty flag
   // ************************************************************
   wire load = (state_reg == AST_LOAD);
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         hold_reg <= `AST_HOLD_RESET;
         hold_full_reg <= 1'b0;
         hold_nine_reg <= 1'b0;
      end else if (!transmit_enable) begin
         hold_full_reg <= 1'b0;
      end else if (wr_hold) begin
         // ninth bit captured with the data, so it must be written first
         hold_reg <= apb_req_i.pwdata[7:0];
         hold_nine_reg <= txsc_reg[`AST_BIT_NINTH];
         hold_full_reg <= 1'b1;
      end else if (load) begin
         hold_full_reg <= 1'b0;
      end
   end

   // flag is pure hardware state; no bus path writes it
   wire busy = (state_reg == AST_SEND);
   wire flag_next = transmit_enable & ~(busy & hold_full_reg);
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         flag_reg <= 1'b0;
         wr_age_reg <= 2'd0;
      end else begin
         flag_reg <= flag_next;
         wr_age_reg <= wr_hold ? 2'd1 : (wr_age_reg != 2'd0 ? wr_age_reg + 2'd1 : 2'd0);
      end
   end

   // interrupt gated by all three enables; flag itself unaffected
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= flag_next & (&intc_reg);
   end

   // ************************************************************
   // baud generator and shifter
   // ************************************************************
   wire baud_tick = (baud_cnt_reg == '0);
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         baud_cnt_reg <= '0;
      else
         // restart on load so the start bit is a full bit time, not a stub
         baud_cnt_reg <= (baud_tick | load) ? baud_reg : baud_cnt_reg - 1'b1;
   end

   // frame: start + data (8/9) + one stop
   wire [3:0] last_bit = nine ? 4'd10 : 4'd9;
   ast_state_e state_next;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         AST_IDLE: if (tx_active & hold_full_reg) state_next = AST_LOAD;
         AST_LOAD: state_next = AST_SEND;
         AST_SEND: begin
            if (!tx_active)
               state_next = AST_IDLE;
            else if (baud_tick && bit_cnt_reg == last_bit)
               state_next = hold_full_reg ? AST_LOAD : AST_IDLE;
         end
         default: state_next = AST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg <= AST_IDLE;
         shift_reg <= 9'h1FF;
         bit_cnt_reg <= 4'd0;
         tx_line_reg <= 1'b1;
         shift_reg_empty_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         if (load) begin
            shift_reg <= {nine ? hold_nine_reg : 1'b1, hold_reg};
            bit_cnt_reg <= 4'd0;
            tx_line_reg <= 1'b0;
            shift_reg_empty_reg <= 1'b0;
         end else if (busy && baud_tick) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == last_bit - 4'd1 || !tx_active)
               tx_line_reg <= 1'b1;
            else begin
               tx_line_reg <= shift_reg[0];
               shift_reg <= {1'b1, shift_reg[8:1]};
            end
         end else if (state_reg == AST_IDLE) begin
            tx_line_reg <= 1'b1;
            shift_reg_empty_reg <= 1'b1;
         end
      end
   end

   // ************************************************************
   // pins
   // ************************************************************
   logic [2:0] rx_sync_reg;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tx_pin_o <= 1'b1;
         tx_pin_oe_n_o <= 1'b1;
         rx_pin_o <= 1'b0;
         rx_pin_oe_n_o <= 1'b1;
         rx_sync_reg <= 3'b111;
         rx_level_o <= 1'b1;
         port_latch_reg <= 8'h00;
      end else begin
         tx_pin_o <= tx_line_reg;
         tx_pin_oe_n_o <= ~serial_port_enable;
         rx_pin_o <= 1'b0;
         rx_pin_oe_n_o <= 1'b1;
         rx_sync_reg <= {rx_sync_reg[1:0], rx_pin_i};
         if (rx_sync_reg[1] == rx_sync_reg[2])
            rx_level_o <= rx_sync_reg[2];
         port_latch_reg <= 8'h00;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_load;
      state_reg == AST_LOAD;
   endsequence
   sequence s_start;
      tx_line_reg == 1'b0 && shift_reg_empty_reg == 1'b0;
   endsequence

   AST_IDLE_MARK: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == AST_IDLE |=> tx_line_reg)
      else $error("line not at mark while idle");
   AST_LOAD_START: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_load |=> s_start)
      else $error("no start bit after load");
   AST_SHIFT_REG_EMPTY_LOAD: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_load |=> !shift_reg_empty_reg)
      else $error("shifter empty not cleared on load");
   AST_IDLE_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == AST_IDLE && tx_active && hold_full_reg |=> s_load)
      else $error("idle write not loaded");
   AST_FLAG_BUSY: assert property (@(posedge mclk_i) disable iff (rst_i)
      busy && hold_full_reg && transmit_enable |=> !flag_reg)
      else $error("flag set while holding full");
   AST_FLAG_TRANSMIT_ENABLE: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(transmit_enable) |=> flag_reg)
      else $error("flag not set on enable");
   AST_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
      flag_reg && (&intc_reg) && $stable(intc_reg) |-> irq_o)
      else $error("interrupt missing");
   AST_PIN_DIR: assert property (@(posedge mclk_i) disable iff (rst_i)
      serial_port_enable |=> !tx_pin_oe_n_o && rx_pin_oe_n_o)
      else $error("pin direction wrong");
   AST_FLAG_AGE: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_age_reg == `AST_FLAG_LAT |-> flag_reg == $past(flag_next))
      else $error("flag not valid two cycles after write");

   // bit-level checks of the frame in flight, then baud, load, status, flag, interrupt, pin and bus checks
   sequence s_stop_tick;
      busy && baud_tick && bit_cnt_reg == last_bit - 4'd1;
   endsequence
   sequence s_data_tick;
      busy && baud_tick && tx_active && bit_cnt_reg < last_bit - 4'd1;
   endsequence

   AST_STOP_MARK: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_stop_tick |=> tx_line_reg)
      else $error("stop bit not at mark");
   AST_LSB_FIRST: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_data_tick |=> tx_line_reg == $past(shift_reg[0]))
      else $error("data bit not taken from shifter lsb");
   AST_BIT_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
      busy && !baud_tick && tx_active |=> $stable(tx_line_reg))
      else $error("line changed inside a bit time");
   AST_BAUD_PERIOD: assert property (@(posedge mclk_i) disable iff (rst_i)
      baud_tick |=> baud_cnt_reg == $past(baud_reg))
      else $error("baud counter not reloaded on tick");
   AST_LOAD_BAUD: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_load |=> baud_cnt_reg == $past(baud_reg))
      else $error("baud counter not restarted on load");
   AST_SHIFT_REG_EMPTY_IDLE: assert property (@(posedge mclk_i) disable iff (rst_i)
      state_reg == AST_IDLE |=> shift_reg_empty_reg)
      else $error("shifter empty not set while idle");
   AST_SHIFT_REG_EMPTY_BUSY: assert property (@(posedge mclk_i) disable iff (rst_i)
      busy |-> !shift_reg_empty_reg)
      else $error("shifter empty set while sending");
   AST_NINTH_LOAD: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_load && nine |=> shift_reg[8] == $past(hold_nine_reg))
      else $error("ninth bit not loaded as msb");
   AST_FLAG_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
      !transmit_enable |=> !flag_reg)
      else $error("flag set while transmitter disabled");
   AST_IRQ_MASK: assert property (@(posedge mclk_i) disable iff (rst_i)
      !(&intc_reg) |=> !irq_o)
      else $error("interrupt raised while masked");
   AST_RX_FILTER: assert property (@(posedge mclk_i) disable iff (rst_i)
      rx_sync_reg[1] == rx_sync_reg[2] |=> rx_level_o == $past(rx_sync_reg[2]))
      else $error("receive level not taken when stages agree");
   AST_TX_PIN: assert property (@(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> tx_pin_o == $past(tx_line_reg))
      else $error("transmit pin does not follow line");
   AST_APB_READY: assert property (@(posedge mclk_i) disable iff (rst_i)
      setup |=> apb_rsp_o.pready)
      else $error("no ready after setup");
endmodule

// ==== common/ast_cfg.svh ====
// register offsets, field positions, reset values and timing counts for the serial transmitter
`ifndef AST_CFG_SVH
`define AST_CFG_SVH
`define AST_OFF_TXSC 12'h000
`define AST_OFF_RXSC 12'h004
`define AST_OFF_BAUD 12'h008
`define AST_OFF_HOLD 12'h00C
`define AST_OFF_INTC 12'h010
`define AST_OFF_FLAG 12'h014
`define AST_TXSC_RESET 8'h02
`define AST_RXSC_RESET 8'h00
`define AST_BAUD_RESET 8'h00
`define AST_HOLD_RESET 8'h00
`define AST_BIT_CLKMODE 7
`define AST_BIT_NINE 6
`define AST_BIT_TRANSMIT_ENABLE 5
`define AST_BIT_SYNC 4
`define AST_BIT_HISPD 2
`define AST_BIT_SHIFT_REG_EMPTY 1
`define AST_BIT_NINTH 0
`define AST_BIT_SERIAL_PORT_ENABLE 7
`define AST_BIT_GIE 2
`define AST_BIT_PERIPHERAL_INT_ENABLE 1
`define AST_BIT_TX_INTERRUPT_ENABLE 0
`define AST_FLAG_LAT 2'd2
`endif

// ==== common/ast_pkg.sv ====
// types shared by the serial transmitter
package ast_pkg;
   typedef enum logic [2:0] {
      AST_IDLE = 3'b001,
      AST_LOAD = 3'b010,
      AST_SEND = 3'b100
   } ast_state_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ast_apb_req_s;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ast_apb_rsp_s;
endpackage

// ==== dv/ast_rx_model.sv ====
// far-end receiver model that samples the transmit line mid-bit
`timescale 1ns/100ps
module ast_rx_model #(
   parameter int BT = 4
) (
   input wire logic mclk_i,
   input wire logic line_i,
   input wire logic nine_i,
   input wire logic drive_i,
   output logic rx_o,
   output logic [8:0] word_o,
   output logic stop_o,
   output int cnt_o
);
   int i;
   // idle mark unless the bench commands a space level
   assign rx_o = drive_i;
   initial begin
      word_o = '0;
      stop_o = 1'b0;
      cnt_o = 0;
      forever begin
         @(posedge mclk_i);
         if (line_i === 1'b0) begin
            repeat (BT / 2) @(posedge mclk_i);
            // a start that is gone by mid-bit is a glitch, not a frame
            if (line_i === 1'b0) begin
               word_o = '0;
               for (i = 0; i < (nine_i ? 9 : 8); i++) begin
                  repeat (BT) @(posedge mclk_i);
                  word_o[i] = line_i;
               end
               repeat (BT) @(posedge mclk_i);
               stop_o = line_i;
               cnt_o++;
            end
         end
      end
   end
endmodule

// ==== dv/ast_tx_bench.sv ====
// self-checking bench for the serial transmitter over apb
`timescale 1ns/100ps
`include "ast_cfg.svh"
module ast_tx_bench;
   import ast_pkg::*;
   logic mclk;
   logic rst;
   ast_apb_req_s req;
   ast_apb_rsp_s rsp;
   logic tx_pin, tx_oe_n, rx_oe_n, rx_lvl, irq, nine, drv, rx_line, stop, err;
   logic [8:0] word;
   logic [31:0] rd;
   int cnt;
   int n_fail;
   int checked;
   wire logic line = tx_oe_n ? 1'b1 : tx_pin;
   ast_tx ast_tx_inst (.mclk_i(mclk), .rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
      .rx_pin_i(rx_line), .tx_pin_o(tx_pin), .tx_pin_oe_n_o(tx_oe_n), .rx_pin_o(),
      .rx_pin_oe_n_o(rx_oe_n), .rx_level_o(rx_lvl), .irq_o(irq));
   ast_rx_model #(.BT(4)) ast_rx_model_inst (.mclk_i(mclk), .line_i(line), .nine_i(nine),
      .drive_i(drv), .rx_o(rx_line), .word_o(word), .stop_o(stop), .cnt_o(cnt));
   // ****************
   // tasks
   // ****************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // entered just after a rising edge; two idle edges let registered effects show
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge mclk);
      @(posedge mclk);
      if (k >= 20) begin
         chk("pready", 1, 0);
         tally_and_finish();
      end
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_cnt(input int n);
      int k;
      for (k = 0; k < 600 && cnt < n; k++) begin
         @(posedge mclk);
      end
      if (cnt < n) begin
         chk("frame count", n, cnt);
         tally_and_finish();
      end
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      n_fail = 0;
      checked = 0;
      req = '0;
      rst = 1'b1;
      nine = 1'b0;
      drv = 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk("line idle", 1, 32'(tx_pin));
      chk("oe_n reset", 1, 32'(tx_oe_n));
      rdc("txsc reset", `AST_OFF_TXSC, 32'h02);
      rdc("baud reset", `AST_OFF_BAUD, 32'h00);
      rdc("hold read", `AST_OFF_HOLD, 32'h00);
      rdc("unmapped", 12'h0FC, 32'h00);
      chk("slverr", 1, 32'(err));
      $display("test reset done");
      // software set-up order kept here
      apb(1'b1, `AST_OFF_BAUD, 32'h03);
      apb(1'b1, `AST_OFF_RXSC, 32'h80);
      chk("tx oe_n", 0, 32'(tx_oe_n));
      chk("rx oe_n", 1, 32'(rx_oe_n));
      apb(1'b1, `AST_OFF_TXSC, 32'h20);
      rdc("flag on enable", `AST_OFF_FLAG, 32'h01);
      apb(1'b1, `AST_OFF_HOLD, 32'hA5);
      rdc("shift_reg_empty busy", `AST_OFF_TXSC, 32'h20);
      apb(1'b1, `AST_OFF_HOLD, 32'h3C);
      rdc("flag queued", `AST_OFF_FLAG, 32'h00);
      wait_cnt(1);
      chk("char 1", 32'h0A5, 32'(word));
      chk("stop 1", 1, 32'(stop));
      wait_cnt(2);
      chk("char 2", 32'h03C, 32'(word));
      repeat (8) @(posedge mclk);
      rdc("shift_reg_empty idle", `AST_OFF_TXSC, 32'h22);
      rdc("flag idle", `AST_OFF_FLAG, 32'h01);
      $display("test eight-bit done");
      nine = 1'b1;
      apb(1'b1, `AST_OFF_TXSC, 32'h61);
      apb(1'b1, `AST_OFF_HOLD, 32'h55);
      wait_cnt(3);
      chk("nine-bit char", 32'h155, 32'(word));
      chk("stop 3", 1, 32'(stop));
      repeat (8) @(posedge mclk);
      $display("test nine-bit done");
      apb(1'b1, `AST_OFF_INTC, 32'h06);
      chk("irq masked", 0, 32'(irq));
      apb(1'b1, `AST_OFF_INTC, 32'h07);
      chk("irq raised", 1, 32'(irq));
      apb(1'b1, `AST_OFF_INTC, 32'h06);
      chk("irq dropped", 0, 32'(irq));
      $display("test interrupt done");
      nine = 1'b0;
      // clocked mode blocks asynchronous sending
      apb(1'b1, `AST_OFF_TXSC, 32'h30);
      apb(1'b1, `AST_OFF_HOLD, 32'h0F);
      repeat (60) @(posedge mclk);
      chk("no frame in sync", 3, cnt);
      chk("line mark", 1, 32'(tx_pin));
      drv <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("rx level", 0, 32'(rx_lvl));
      rdc("rx read", `AST_OFF_RXSC, 32'h80);
      $display("test mode and pin done");
      tally_and_finish();
   end
endmodule
